// [rtl/cbd_agu.sv]
// Effective address generator for the data addressing modes.
`default_nettype none
module cbd_agu
  import cbd_pkg::*;
(
  // Mode and base registers
  input wire logic [3:0] mode,
  input wire logic [15:0] idx,
  input wire logic [15:0] sp,
  input wire logic [15:0] opnd,
  // Effective address
  output logic [15:0] ea
);
  always_comb begin
    case (mode)
      AM_DIRECT: ea = {8'h00, opnd[7:0]};
      AM_FULL_ADDRESS: ea = opnd;
      AM_INDEX, AM_INDEX_AUTOINC: ea = idx;
      AM_INDEX_BYTE_OFFSET, AM_INDEX_BYTE_OFFSET_AUTOINC: begin
        ea = idx + {8'h00, opnd[7:0]};
      end
      AM_INDEX_WORD_OFFSET: ea = idx + opnd;
      AM_STACK_BYTE_OFFSET: ea = sp + {8'h00, opnd[7:0]};
      AM_STACK_WORD_OFFSET: ea = sp + opnd;
      default: ea = opnd;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/cbd_core.sv]
// Bus-cycle sequencer with addressing decode, flags and an Avalon-MM register port.
// Behaviour
// - A free cycle lasts one bus clock, carries no real data and is issued as a read.
// - A fetch reads the next program location and advances the program counter by one.
// - Operand reads and writes move exactly one byte per bus cycle.
// - A push writes one byte at the stack pointer, which then points one lower.
// - A pop moves the stack pointer up by one first and then reads one byte there.
// - A vector is read from the top page, high byte first, then the low byte.
// - The condition flags hold overflow, half-carry, interrupt mask, negative, zero, carry.
// - The index register is two byte halves, high and low, joined high-to-low.
// - Indexed post-increment uses the index as address and then increments it.
// - Byte-offset post-increment adds the unsigned offset, then increments the index.
// - Indexed addresses are index plus zero, an unsigned byte or a 16-bit offset.
// - Stack-relative addresses are stack pointer plus a byte or 16-bit offset.
// - Relative mode adds one signed offset byte to the program counter.
// - Subtraction and negation use two's complement arithmetic.
// - Branch reach is 128 back to 127 forward from the next instruction.
// - Direct mode forces the upper address byte to zero.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`default_nettype none
module cbd_core
  import cbd_pkg::*;
(
  // Clock, reset and clock enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Avalon-MM register slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // System bus
  output logic sb_cyc,
  output logic sb_rd,
  output logic sb_wr,
  output logic [2:0] sb_kind,
  output logic [15:0] sb_addr,
  output logic [7:0] sb_wdata,
  input wire logic [7:0] sb_rdata
);
  cbd_state_t state_r;
  logic [15:0] pc_r, sp_r, opnd_r;
  logic [7:0] wbyte_r, idx_hi_r, idx_lo_r, flags_r, alu_res_r, rd_byte_r;
  logic [2:0] kind_r;
  logic [3:0] mode_r;
  logic cyc_r, rd_r, wr_r;
  logic [15:0] addr_r;
  logic [7:0] wdata_r;
  logic [31:0] rdata_r;
  logic rd_ack_r;
  logic [31:0] rdata_nxt;
  logic [15:0] idx, ea, l_addr;
  logic l_rd, l_wr, wr_go, cmd_go, launch, branch_go, alu_go;
  logic [2:0] cmd_kind;
  logic [3:0] cmd_mode;
  logic [7:0] alu_x, alu_y;
  logic [8:0] alu_diff;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] be);
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  function automatic logic is_rw(input logic [2:0] kind);
    is_rw = (kind == CY_READ) || (kind == CY_WRITE);
  endfunction

  function automatic logic is_autoinc(input logic [3:0] mode);
    is_autoinc = (mode == AM_INDEX_AUTOINC) || (mode == AM_INDEX_BYTE_OFFSET_AUTOINC);
  endfunction

  assign idx = {idx_hi_r, idx_lo_r};
  assign cmd_kind = avs_writedata[CMD_KIND_LSB +: 3];
  assign cmd_mode = avs_writedata[CMD_MODE_LSB +: 4];

  // Writes wait while a bus cycle runs; reads take one extra clock for registered data.
  assign avs_waitrequest = !ce || (avs_read && !rd_ack_r) || (avs_write && state_r != ST_IDLE);
  assign wr_go = avs_write && !avs_waitrequest;
  assign cmd_go = wr_go && avs_address == OFS_CMD;
  assign launch = cmd_go && cmd_kind != CY_BRANCH;
  assign branch_go = cmd_go && cmd_kind == CY_BRANCH;
  assign alu_go = wr_go && avs_address == OFS_ALU;

  assign avs_readdata = rdata_r;
  assign sb_cyc = cyc_r;
  assign sb_rd = rd_r;
  assign sb_wr = wr_r;
  assign sb_kind = kind_r;
  assign sb_addr = addr_r;
  assign sb_wdata = wdata_r;

  cbd_agu cbd_agu_inst (
    .mode(cmd_mode),
    .idx(idx),
    .sp(sp_r),
    .opnd(opnd_r),
    .ea(ea)
  );

  // Address and direction of the cycle about to be launched.
  always_comb begin
    l_addr = pc_r;
    l_rd = 1'b1;
    l_wr = 1'b0;
    case (cmd_kind)
      CY_READ: l_addr = ea;
      CY_WRITE: begin
        l_addr = ea;
        l_rd = 1'b0;
        l_wr = 1'b1;
      end
      CY_PUSH: begin
        l_addr = sp_r;
        l_rd = 1'b0;
        l_wr = 1'b1;
      end
      CY_POP: l_addr = sp_r + 16'h0001;
      CY_VECT: l_addr = {VEC_PAGE, opnd_r[7:0]};
      default: l_addr = pc_r;
    endcase
  end

  // Cycle sequencer: one clock per bus cycle, two for a vector.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      case (state_r)
        ST_IDLE: begin
          if (launch) begin
            state_r <= ST_BUS;
          end
        end
        ST_BUS: begin
          if (kind_r == CY_VECT) begin
            state_r <= ST_VLO;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_VLO: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // System bus outputs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_r <= 1'b0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
      kind_r <= CY_FREE;
      mode_r <= AM_DIRECT;
    end else if (ce) begin
      if (launch) begin
        cyc_r <= 1'b1;
        rd_r <= l_rd;
        wr_r <= l_wr;
        addr_r <= l_addr;
        wdata_r <= wbyte_r;
        kind_r <= cmd_kind;
        mode_r <= cmd_mode;
      end else if (state_r == ST_BUS && kind_r == CY_VECT) begin
        addr_r <= {VEC_PAGE, addr_r[7:0] + 8'h01};
      end else begin
        cyc_r <= 1'b0;
        rd_r <= 1'b0;
        wr_r <= 1'b0;
      end
    end
  end

  // Read data capture; a free cycle's data is not real and is dropped.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_byte_r <= 8'h00;
    end else if (ce && cyc_r && rd_r && kind_r != CY_FREE) begin
      rd_byte_r <= sb_rdata;
    end
  end

  // Program counter.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_r <= PC_RST;
    end else if (ce) begin
      if (wr_go && avs_address == OFS_PC) begin
        pc_r <= merge16(pc_r, avs_writedata[15:0], avs_byteenable[1:0]);
      end else if (branch_go) begin
        pc_r <= pc_r + {{8{opnd_r[7]}}, opnd_r[7:0]};
      end else if (state_r == ST_BUS && kind_r == CY_FETCH) begin
        pc_r <= pc_r + 16'h0001;
      end else if (state_r == ST_VLO) begin
        pc_r <= {rd_byte_r, sb_rdata};
      end
    end
  end

  // Stack pointer.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_r <= SP_RST;
    end else if (ce) begin
      if (wr_go && avs_address == OFS_SP) begin
        sp_r <= merge16(sp_r, avs_writedata[15:0], avs_byteenable[1:0]);
      end else if (state_r == ST_BUS && kind_r == CY_PUSH) begin
        sp_r <= sp_r - 16'h0001;
      end else if (state_r == ST_BUS && kind_r == CY_POP) begin
        sp_r <= sp_r + 16'h0001;
      end
    end
  end

  // Index register halves, each written on its own byte lane.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_hi_r <= 8'h00;
      idx_lo_r <= 8'h00;
    end else if (ce) begin
      if (wr_go && avs_address == OFS_IDX) begin
        if (avs_byteenable[1]) begin
          idx_hi_r <= avs_writedata[15:8];
        end
        if (avs_byteenable[0]) begin
          idx_lo_r <= avs_writedata[7:0];
        end
      end else if (state_r == ST_BUS && is_rw(kind_r) && is_autoinc(mode_r)) begin
        {idx_hi_r, idx_lo_r} <= idx + 16'h0001;
      end
    end
  end

  // Operand bytes and write byte for the next cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opnd_r <= 16'h0000;
      wbyte_r <= 8'h00;
    end else if (ce && wr_go && avs_address == OFS_OPND) begin
      opnd_r <= merge16(opnd_r, avs_writedata[15:0], avs_byteenable[1:0]);
      if (avs_byteenable[2]) begin
        wbyte_r <= avs_writedata[OPND_WBYTE_LSB +: 8];
      end
    end
  end

  // Subtract or negate: minuend plus inverted subtrahend plus one.
  always_comb begin
    alu_x = avs_writedata[ALU_NEG_BIT] ? 8'h00 : avs_writedata[7:0];
    alu_y = avs_writedata[ALU_NEG_BIT] ? avs_writedata[7:0] : avs_writedata[ALU_M_LSB +: 8];
    alu_diff = {1'b0, alu_x} + {1'b0, ~alu_y} + 9'h001;
  end

  // Condition flags and arithmetic result.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= FLAGS_RST;
      alu_res_r <= 8'h00;
    end else if (ce) begin
      if (wr_go && avs_address == OFS_FLAGS && avs_byteenable[0]) begin
        flags_r <= avs_writedata[7:0] | FLAGS_ONES;
      end else if (alu_go) begin
        alu_res_r <= alu_diff[7:0];
        flags_r[FL_N] <= alu_diff[7];
        flags_r[FL_Z] <= alu_diff[7:0] == 8'h00;
        flags_r[FL_C] <= !alu_diff[8];
        flags_r[FL_V] <= (alu_x[7] ^ alu_y[7]) & (alu_x[7] ^ alu_diff[7]);
      end
    end
  end

  // Register read decode.
  always_comb begin
    if (avs_address == OFS_CMD) begin
      rdata_nxt = {24'h000000, mode_r, 1'b0, kind_r};
    end else if (avs_address == OFS_OPND) begin
      rdata_nxt = {8'h00, wbyte_r, opnd_r};
    end else if (avs_address == OFS_PC) begin
      rdata_nxt = {16'h0000, pc_r};
    end else if (avs_address == OFS_SP) begin
      rdata_nxt = {16'h0000, sp_r};
    end else if (avs_address == OFS_IDX) begin
      rdata_nxt = {16'h0000, idx};
    end else if (avs_address == OFS_FLAGS) begin
      rdata_nxt = {24'h000000, flags_r};
    end else if (avs_address == OFS_STAT) begin
      rdata_nxt = {addr_r, rd_byte_r, 7'h00, state_r != ST_IDLE};
    end else if (avs_address == OFS_ALU) begin
      rdata_nxt = {24'h000000, alu_res_r};
    end else begin
      rdata_nxt = 32'h00000000;
    end
  end

  // Read answer register.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 32'h00000000;
      rd_ack_r <= 1'b0;
    end else if (ce) begin
      rd_ack_r <= avs_read && !rd_ack_r;
      if (avs_read && !rd_ack_r) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  free_one_read_a: assert property (
    cyc_r && kind_r == CY_FREE && ce |-> rd_r && !wr_r ##1 !cyc_r)
    else $error("free cycle is not a single read clock");
  fetch_pc_step_a: assert property (
    state_r == ST_BUS && kind_r == CY_FETCH && ce |-> addr_r == pc_r ##1
    pc_r == $past(pc_r) + 16'h0001)
    else $error("fetch did not advance program counter by one");
  one_byte_cycle_a: assert property (
    cyc_r && is_rw(kind_r) && ce |-> (rd_r != wr_r) ##1 !cyc_r)
    else $error("operand cycle not one byte in one clock");
  push_sp_a: assert property (
    cyc_r && kind_r == CY_PUSH && ce |-> wr_r && addr_r == sp_r ##1
    sp_r == $past(sp_r) - 16'h0001)
    else $error("push address or stack step wrong");
  pop_sp_a: assert property (
    cyc_r && kind_r == CY_POP && ce |-> rd_r && addr_r == sp_r + 16'h0001 ##1
    sp_r == $past(sp_r) + 16'h0001)
    else $error("pop address or stack step wrong");
  vector_order_a: assert property (
    state_r == ST_BUS && kind_r == CY_VECT && ce |-> addr_r[15:8] == VEC_PAGE ##1
    state_r == ST_VLO && addr_r[7:0] == $past(addr_r[7:0]) + 8'h01)
    else $error("vector bytes out of order");
  index_halves_a: assert property (
    wr_go && avs_address == OFS_IDX && avs_byteenable[1:0] == 2'b10 |=>
    idx_lo_r == $past(idx_lo_r) && idx_hi_r == $past(avs_writedata[15:8]))
    else $error("index half written on wrong lane");
  autoinc_step_a: assert property (
    state_r == ST_BUS && is_rw(kind_r) && is_autoinc(mode_r) && ce |=>
    idx == $past(idx) + 16'h0001)
    else $error("index not incremented after access");
  word_offset_a: assert property (
    launch && kind_r != CY_VECT && cmd_kind == CY_READ && cmd_mode == AM_INDEX_WORD_OFFSET |=>
    addr_r == $past(idx) + $past(opnd_r))
    else $error("indexed word offset address wrong");
  branch_reach_a: assert property (
    branch_go |=> pc_r == $past(pc_r) + {{8{$past(opnd_r[7])}}, $past(opnd_r[7:0])})
    else $error("branch target wrong");
  direct_page_a: assert property (
    launch && is_rw(cmd_kind) && cmd_mode == AM_DIRECT |=>
    addr_r == {8'h00, $past(opnd_r[7:0])})
    else $error("direct address not on first page");
  twos_sub_a: assert property (
    alu_go && !avs_writedata[ALU_NEG_BIT] |=>
    alu_res_r == 8'($past(avs_writedata[7:0]) - $past(avs_writedata[15:8])))
    else $error("subtract result wrong");

  vector_walk_c: cover property (state_r == ST_VLO && ce ##1 state_r == ST_IDLE);
  branch_back_c: cover property (branch_go && opnd_r[7]);
  push_pop_c: cover property (cyc_r && kind_r == CY_PUSH ##[1:20] cyc_r && kind_r == CY_POP);
endmodule
`default_nettype wire

// [rtl/cbd_pkg.sv]
// Package with the register map, cycle kinds, addressing modes and flag layout.
`default_nettype none
package cbd_pkg;
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_OPND = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_SP = 8'h0C;
  localparam logic [7:0] OFS_IDX = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_ALU = 8'h1C;
  // Field positions.
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_MODE_LSB = 4;
  localparam int OPND_WBYTE_LSB = 16;
  localparam int ALU_M_LSB = 8;
  localparam int ALU_NEG_BIT = 16;
  // Condition flag bit positions.
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_I = 3;
  localparam int FL_H = 4;
  localparam int FL_V = 7;
  // Reset values and fixed bits.
  localparam logic [7:0] FLAGS_ONES = 8'h60;
  localparam logic [7:0] FLAGS_RST = 8'h68;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h00FF;
  localparam logic [7:0] VEC_PAGE = 8'hFF;
  // Bus cycle kinds.
  localparam logic [2:0] CY_FREE = 3'h0;
  localparam logic [2:0] CY_FETCH = 3'h1;
  localparam logic [2:0] CY_READ = 3'h2;
  localparam logic [2:0] CY_WRITE = 3'h3;
  localparam logic [2:0] CY_PUSH = 3'h4;
  localparam logic [2:0] CY_POP = 3'h5;
  localparam logic [2:0] CY_VECT = 3'h6;
  localparam logic [2:0] CY_BRANCH = 3'h7;
  // Addressing modes.
  localparam logic [3:0] AM_DIRECT = 4'h0;
  localparam logic [3:0] AM_FULL_ADDRESS = 4'h1;
  localparam logic [3:0] AM_INDEX = 4'h2;
  localparam logic [3:0] AM_INDEX_BYTE_OFFSET = 4'h3;
  localparam logic [3:0] AM_INDEX_WORD_OFFSET = 4'h4;
  localparam logic [3:0] AM_INDEX_AUTOINC = 4'h5;
  localparam logic [3:0] AM_INDEX_BYTE_OFFSET_AUTOINC = 4'h6;
  localparam logic [3:0] AM_STACK_BYTE_OFFSET = 4'h7;
  localparam logic [3:0] AM_STACK_WORD_OFFSET = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUS = 3'b010,
    ST_VLO = 3'b100
  } cbd_state_t;
endpackage
`default_nettype wire

// [tb/cbd_core_tb.sv]
// Self-checking bench for the bus-cycle sequencer and its register port.
`default_nettype none
module cbd_core_tb
  import cbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n, ce, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [3:0] avs_byteenable;
  logic sb_cyc, sb_rd, sb_wr, last_rd, last_wr;
  logic [2:0] sb_kind, last_kind;
  logic [15:0] sb_addr;
  logic [7:0] sb_wdata, sb_rdata, last_wd;
  logic [15:0] aq[$];
  int error_cnt, checks;
  localparam logic [15:0] EXP_EA [9] = '{16'h00F0, 16'h34F0, 16'h1200, 16'h12F0, 16'h46F0,
    16'h1200, 16'h12F0, 16'h03F0, 16'h37F0};
  localparam logic [31:0] ALU_TAB [4] = '{{15'h0, 1'b0, 8'h20, 8'h10}, {15'h0, 1'b1, 8'h00, 8'h00},
    {15'h0, 1'b1, 8'h00, 8'h80}, {15'h0, 1'b0, 8'h01, 8'h80}};
  localparam logic [7:0] ALU_FL [4] = '{8'h6D, 8'h6A, 8'hED, 8'hE8};
  localparam logic [7:0] ALU_RES [4] = '{8'hF0, 8'h00, 8'h80, 8'h7F};

  always #2.5 clk = ~clk;

  cbd_core cbd_core_inst (.clk(clk), .arst_n(arst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sb_cyc(sb_cyc), .sb_rd(sb_rd), .sb_wr(sb_wr),
    .sb_kind(sb_kind), .sb_addr(sb_addr), .sb_wdata(sb_wdata), .sb_rdata(sb_rdata));
  cbd_mem_model cbd_mem_model_inst (.clk(clk), .sb_cyc(sb_cyc), .sb_rd(sb_rd), .sb_wr(sb_wr),
    .sb_addr(sb_addr), .sb_wdata(sb_wdata), .sb_rdata(sb_rdata));

  // Records every system bus cycle so a command's traffic can be inspected afterwards.
  always @(posedge clk) begin
    if (sb_cyc === 1'b1) begin
      aq.push_back(sb_addr);
      last_rd <= sb_rd;
      last_wr <= sb_wr;
      last_wd <= sb_wdata;
      last_kind <= sb_kind;
    end
  end

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon transfer; the request is held until waitrequest is seen low at a rising edge.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] be);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      report_and_stop();
    end
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    xfer(1'b1, a, d, be);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0, 4'hF);
  endtask

  // Launches one command and polls the busy flag until it clears.
  task automatic run(input logic [2:0] kind, input logic [3:0] mode);
    int n;
    aq.delete();
    wr(OFS_CMD, {24'h0, mode, 1'b0, kind}, 4'hF);
    n = 0;
    do begin
      rd(OFS_STAT);
      n++;
    end while (rdv[0] !== 1'b0 && n < 20);
    if (rdv[0] !== 1'b0) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    error_cnt = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_PC);
    check("pc reset", 32'(rdv[15:0]), 32'(PC_RST));
    rd(OFS_SP);
    check("sp reset", 32'(rdv[15:0]), 32'(SP_RST));
    rd(OFS_FLAGS);
    check("flags reset", 32'(rdv[7:0]), 32'h68);
    wr(OFS_PC, 32'h0000_1234, 4'h3);
    for (int i = 0; i < 2; i++) begin
      run(CY_FETCH, AM_DIRECT);
      check("fetch count", 32'(aq.size()), 32'h1);
      check("fetch addr", 32'(aq[0]), 32'(16'h1234 + 16'(i)));
      rd(OFS_STAT);
      check("fetch byte", 32'(rdv[15:8]), 32'(pat(16'h1234 + 16'(i))));
    end
    rd(OFS_PC);
    check("pc after fetch", 32'(rdv[15:0]), 32'h1236);
    run(CY_FREE, AM_DIRECT);
    check("free count", 32'(aq.size()), 32'h1);
    check("free dir", {30'h0, last_rd, last_wr}, 32'h2);
    check("free kind", 32'(last_kind), 32'(CY_FREE));
    wr(OFS_SP, 32'h0000_0300, 4'h3);
    wr(OFS_OPND, 32'h00C3_34F0, 4'h7);
    for (int i = 0; i < 9; i++) begin
      wr(OFS_IDX, 32'h0000_1200, 4'h3);
      run(CY_READ, 4'(i));
      check("ea", 32'(aq[0]), 32'(EXP_EA[i]));
      check("read count", 32'(aq.size()), 32'h1);
      rd(OFS_STAT);
      check("read byte", 32'(rdv[15:8]), 32'(pat(EXP_EA[i])));
      rd(OFS_IDX);
      check("idx after", 32'(rdv[15:0]), (i == 5 || i == 6) ? 32'h1201 : 32'h1200);
    end
    wr(OFS_IDX, 32'h0000_AB77, 4'h1);
    rd(OFS_IDX);
    check("idx low half", 32'(rdv[15:0]), 32'h1277);
    wr(OFS_IDX, 32'h0000_AB77, 4'h2);
    rd(OFS_IDX);
    check("idx high half", 32'(rdv[15:0]), 32'hAB77);
    run(CY_WRITE, AM_FULL_ADDRESS);
    check("write count", 32'(aq.size()), 32'h1);
    check("write dir", {30'h0, last_rd, last_wr}, 32'h1);
    check("write byte", 32'(cbd_mem_model_inst.mem[16'h34F0]), 32'hC3);
    wr(OFS_SP, 32'h0000_0080, 4'h3);
    wr(OFS_OPND, 32'h00A5_0000, 4'h4);
    run(CY_PUSH, AM_DIRECT);
    check("push addr", 32'(aq[0]), 32'h0080);
    check("push byte", 32'(cbd_mem_model_inst.mem[16'h0080]), 32'hA5);
    check("push data", 32'(last_wd), 32'hA5);
    check("push kind", 32'(last_kind), 32'(CY_PUSH));
    rd(OFS_SP);
    check("sp after push", 32'(rdv[15:0]), 32'h007F);
    run(CY_POP, AM_DIRECT);
    check("pop addr", 32'(aq[0]), 32'h0080);
    rd(OFS_STAT);
    check("pop byte", 32'(rdv[15:8]), 32'hA5);
    rd(OFS_SP);
    check("sp after pop", 32'(rdv[15:0]), 32'h0080);
    wr(OFS_OPND, 32'h0000_00FC, 4'h1);
    run(CY_VECT, AM_DIRECT);
    check("vector count", 32'(aq.size()), 32'h2);
    check("vector first", 32'(aq[0]), 32'hFFFC);
    check("vector second", 32'(aq[1]), 32'hFFFD);
    check("vector kind", 32'(last_kind), 32'(CY_VECT));
    rd(OFS_PC);
    check("vector pc", 32'(rdv[15:0]), 32'({pat(16'hFFFC), pat(16'hFFFD)}));
    for (int i = 0; i < 2; i++) begin
      wr(OFS_PC, 32'h0000_1000, 4'h3);
      wr(OFS_OPND, (i == 0) ? 32'h80 : 32'h7F, 4'h1);
      run(CY_BRANCH, AM_DIRECT);
      check("branch no bus", 32'(aq.size()), 32'h0);
      rd(OFS_PC);
      check("branch pc", 32'(rdv[15:0]), (i == 0) ? 32'h0F80 : 32'h107F);
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFS_ALU, ALU_TAB[i], 4'h7);
      rd(OFS_FLAGS);
      check("alu flags", 32'(rdv[7:0]), 32'(ALU_FL[i]));
      rd(OFS_ALU);
      check("alu result", 32'(rdv[7:0]), 32'(ALU_RES[i]));
    end
    wr(OFS_FLAGS, 32'h0000_0000, 4'h1);
    rd(OFS_FLAGS);
    check("flags clear", 32'(rdv[7:0]), 32'(FLAGS_ONES));
    wr(OFS_FLAGS, 32'h0000_009F, 4'h1);
    rd(OFS_FLAGS);
    check("flags set", 32'(rdv[7:0]), 32'hFF);
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_SP);
    check("sp second reset", 32'(rdv[15:0]), 32'(SP_RST));
    rd(OFS_FLAGS);
    check("flags second reset", 32'(rdv[7:0]), 32'(FLAGS_RST));
    report_and_stop();
  end
endmodule
`default_nettype wire

// [tb/cbd_mem_model.sv]
// System bus memory model standing in for program memory and peripherals.
`default_nettype none
module cbd_mem_model (
  // Clock
  input wire logic clk,
  // System bus from the core
  input wire logic sb_cyc,
  input wire logic sb_rd,
  input wire logic sb_wr,
  input wire logic [15:0] sb_addr,
  input wire logic [7:0] sb_wdata,
  output logic [7:0] sb_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
    end
    last_r = 8'h00;
  end
  // Outside a read cycle the data lines show the inverse of the last byte, never a stale copy.
  always_comb begin
    if (sb_cyc && sb_rd) begin
      sb_rdata = mem[sb_addr];
    end else begin
      sb_rdata = ~last_r;
    end
  end
  always @(posedge clk) begin
    if (sb_cyc && sb_rd) begin
      last_r <= mem[sb_addr];
    end
    if (sb_cyc && sb_wr) begin
      mem[sb_addr] <= sb_wdata;
    end
  end
endmodule
`default_nettype wire
